// ==== odc_map.svh ====
/*
  Register map, field positions, reset values and fixed sizes of the output
  buffer and command strobe block.
  Assumes word-indexed Wishbone access: byte address is four times the index.
*/
`ifndef ODC_MAP_SVH
`define ODC_MAP_SVH

// Word indices
`define ODC_IDX_CHAIN_CTRL 6'h00
`define ODC_IDX_PHASE      6'h01
`define ODC_IDX_BUF_CTRL   6'h15
`define ODC_IDX_PTR_RST    6'h16
`define ODC_IDX_ADVANCE    6'h17
`define ODC_IDX_SYNC       6'h18
`define ODC_IDX_GLOBAL_RST 6'h19
`define ODC_IDX_STATUS     6'h1A
`define ODC_IDX_SAMPLE     6'h1B

// Byte address split
`define ODC_ADR_W          8
`define ODC_IDX_HI         7
`define ODC_IDX_LO         2

// Field positions and widths
`define ODC_CTRL_W         16
`define ODC_F_SYNC_SEL     3
`define ODC_PHASE_W        10
`define ODC_PTR_W          3
`define ODC_DEPTH_W        4
`define ODC_NSAMP_MAX      4'h8

// Reset values
`define ODC_RST_BUF_CTRL   16'h0000
`define ODC_RST_CHAIN_CTRL 16'h0000
`define ODC_RST_PHASE      10'h000
`define ODC_RD_PTR_INIT    3'h7
`define ODC_WR_PTR_INIT    3'h0

`endif

// ==== odc_pkg.sv ====
/*
  Shared types of the output buffer and command strobe block.
  Assumes nothing beyond the map header for sizes.
*/
`default_nettype none

package odc_pkg;

  // Output buffer control word, low half
  typedef struct packed {
    logic       fifo_mode;
    logic [2:0] thresh;
    logic [7:0] interval;
    logic [3:0] nsamp;
  } odc_buf_ctrl_t;

  // Reset strobes to the processing-clock stages of the chain
  typedef struct packed {
    logic halfband;
    logic fir;
    logic agc;
    logic resamp;
    logic timing;
  } odc_chain_rst_t;

  // Read-only status word, low bits
  typedef struct packed {
    logic       snap_busy;
    logic       ready;
    logic       full;
    logic       empty;
    logic [3:0] depth;
    logic [2:0] rd_ptr;
    logic [2:0] wr_ptr;
    logic [3:0] group;
  } odc_status_t;

  typedef enum logic {ODC_SNAP_WAIT, ODC_SNAP_CAPTURE} odc_snap_state_t;

endpackage

`default_nettype wire

// ==== odc_sync2.sv ====
/*
  Two-flop synchroniser for levels entering the processing clock domain.
  Assumes its input changes slowly against clk; nothing reads the first flop.
*/
`default_nettype none

module odc_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  // Level in and out
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } odc_sync_state_t;

  odc_sync_state_t state_r;
  odc_sync_state_t state_nxt;

  if (WIDTH < 1) begin : g_chk
    $error("odc_sync2: WIDTH must be at least one");
  end

  always_comb begin
    state_nxt      = state_r;
    state_nxt.meta = async_i;
    state_nxt.sync = state_r.meta;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign sync_o = state_r.sync;

endmodule

`default_nettype wire

// ==== odc_edge_strobe.sv ====
/*
  One-cycle strobe, either passed straight on or held until the next rising
  edge of the input sample clock.
  Assumes trig is a one-cycle pulse and edge a one-cycle pulse, both on clk.
*/
`default_nettype none

module odc_edge_strobe (
  // Clock, reset, enable
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  // Request and alignment
  input  wire logic trig,
  input  wire logic use_edge,
  input  wire logic edge_pulse,
  // Strobe out
  output var  logic strobe_o
);

  typedef struct packed {
    logic pending;
    logic strobe;
  } odc_strobe_state_t;

  odc_strobe_state_t state_r;
  odc_strobe_state_t state_nxt;
  logic              want;

  always_comb begin
    state_nxt = state_r;
    want      = state_r.pending | trig;
    if (use_edge) begin
      // Wait for the sample clock so the strobe lands on its sampling point
      state_nxt.strobe  = want & edge_pulse;
      state_nxt.pending = want & ~edge_pulse;
    end else begin
      state_nxt.strobe  = trig;
      state_nxt.pending = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign strobe_o = state_r.strobe;

endmodule

`default_nettype wire

// ==== odc_buffer_ctrl.sv ====
/*
  Output sample buffer control with its command strobes: snapshot and FIFO
  modes, pointer reset, buffer advance, sync strobe and global chain reset,
  behind a classic Wishbone slave.
  Assumes samples arrive as one-cycle valid pulses on clk, the processing
  clock; the input sample clock arrives as a plain pin and is synchronised.
*/
`default_nettype none
`include "odc_map.svh"

module odc_buffer_ctrl
  import odc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock, reset, enable
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   ce,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`ODC_ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output var  logic [31:0]            wb_dat_o,
  output var  logic                   wb_ack_o,
  // Input sample clock pin
  input  wire logic                   input_sample_clock,
  // Output samples from the chain
  input  wire logic                   samp_valid_i,
  input  wire logic [DATA_W-1:0]      samp_data_i,
  // Device pins
  output var  logic                   sync_strobe_output,
  output var  logic                   buffer_interrupt_output,
  output var  logic                   buffer_ready_o,
  // Chain reset strobes
  output var  odc_chain_rst_t         chain_rst_o,
  output var  logic                   in_dom_rst_o,
  // Carrier oscillator phase
  output var  logic [`ODC_PHASE_W-1:0] nco_phase_o,
  output var  logic                   nco_fb_en_o
);

  localparam int DEPTH = 1 << `ODC_PTR_W;

  typedef logic [`ODC_PTR_W-1:0] odc_ptr_t;

  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    odc_buf_ctrl_t                buf_ctrl;
    logic [`ODC_CTRL_W-1:0]       chain_ctrl;
    logic [`ODC_PHASE_W-1:0]      phase_cfg;
    logic [`ODC_PHASE_W-1:0]      nco_phase;
    logic                         nco_fb_en;
    odc_ptr_t                     rd_ptr;
    odc_ptr_t                     wr_ptr;
    logic [`ODC_DEPTH_W-1:0]      depth;
    logic                         ready;
    logic                         irq;
    odc_snap_state_t              snap_state;
    logic [7:0]                   ivl_cnt;
    logic [3:0]                   group;
    odc_chain_rst_t               chain_rst;
    logic                         sync_req;
    logic                         in_rst_req;
    logic                         in_clk_q;
    logic [31:0]                  rdata;
    logic                         ack;
  } odc_core_state_t;

  odc_core_state_t state_r;
  odc_core_state_t state_nxt;

  if (DATA_W < 1 || DATA_W > 32) begin : g_chk
    $error("odc_buffer_ctrl: DATA_W must lie in 1..32");
  end

  // Input sample clock, synchronised then edge-detected
  logic in_clk_sync;
  logic in_clk_edge;
  logic in_rst_strobe;

  odc_sync2 #(
    .WIDTH (1)
  ) u_in_clk_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .async_i (input_sample_clock),
    .sync_o  (in_clk_sync)
  );

  assign in_clk_edge = in_clk_sync & ~state_r.in_clk_q;

  odc_edge_strobe u_sync_strobe (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .ce         (ce),
    .trig       (state_r.sync_req),
    .use_edge   (state_r.chain_ctrl[`ODC_F_SYNC_SEL]),
    .edge_pulse (in_clk_edge),
    .strobe_o   (sync_strobe_output)
  );

  // The input-domain half of the global reset waits for a sample clock edge
  odc_edge_strobe u_in_rst_strobe (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .ce         (ce),
    .trig       (state_r.in_rst_req),
    .use_edge   (1'b1),
    .edge_pulse (in_clk_edge),
    .strobe_o   (in_rst_strobe)
  );

  // Bus decode
  logic                    req;
  logic                    wr_en;
  logic [5:0]              idx;
  logic                    do_ptr_rst;
  logic                    do_adv;
  logic                    do_sync;
  logic                    do_grst;
  // Buffer datapath
  logic                    push;
  logic                    push_ok;
  logic                    pop;
  logic                    full;
  logic                    empty;
  logic [3:0]              nsamp;
  odc_ptr_t                head;
  odc_status_t             status;

  always_comb begin
    state_nxt = state_r;
    req       = wb_cyc_i & wb_stb_i & ~state_r.ack;
    wr_en     = req & wb_we_i;
    idx       = wb_adr_i[`ODC_IDX_HI:`ODC_IDX_LO];

    // Data is ignored on command addresses; only the write event counts
    do_ptr_rst = wr_en && (idx == `ODC_IDX_PTR_RST);
    do_adv     = wr_en && (idx == `ODC_IDX_ADVANCE);
    do_sync    = wr_en && (idx == `ODC_IDX_SYNC);
    do_grst    = wr_en && (idx == `ODC_IDX_GLOBAL_RST);

    state_nxt.ack        = req;
    state_nxt.rdata      = '0;
    state_nxt.in_clk_q   = in_clk_sync;
    state_nxt.sync_req   = do_sync;
    state_nxt.in_rst_req = do_grst;
    state_nxt.chain_rst  = '0;
    state_nxt.irq        = 1'b0;

    // Configuration writes, byte lanes honoured
    if (wr_en && idx == `ODC_IDX_BUF_CTRL) begin
      if (wb_sel_i[0]) begin
        state_nxt.buf_ctrl[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        state_nxt.buf_ctrl[15:8] = wb_dat_i[15:8];
      end
    end
    if (wr_en && idx == `ODC_IDX_CHAIN_CTRL) begin
      if (wb_sel_i[0]) begin
        state_nxt.chain_ctrl[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        state_nxt.chain_ctrl[15:8] = wb_dat_i[15:8];
      end
    end
    if (wr_en && idx == `ODC_IDX_PHASE) begin
      if (wb_sel_i[0]) begin
        state_nxt.phase_cfg[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        state_nxt.phase_cfg[`ODC_PHASE_W-1:8] = wb_dat_i[`ODC_PHASE_W-1:8];
      end
    end

    // Buffer occupancy
    full  = (state_r.depth == `ODC_DEPTH_W'(DEPTH));
    empty = (state_r.depth == '0);
    nsamp = (state_r.buf_ctrl.nsamp > `ODC_NSAMP_MAX) ? `ODC_NSAMP_MAX : state_r.buf_ctrl.nsamp;
    push  = 1'b0;

    // Sample intake: FIFO takes every sample, snapshot only inside a capture
    if (samp_valid_i) begin
      if (state_r.buf_ctrl.fifo_mode) begin
        push = 1'b1;
      end else begin
        case (state_r.snap_state)
          ODC_SNAP_WAIT: begin
            if (state_r.ivl_cnt == '0) begin
              // Reload gives interval+1 sample times between captures
              state_nxt.ivl_cnt = state_r.buf_ctrl.interval;
              push              = 1'b1;
              state_nxt.group   = 4'h1;
              if (nsamp > 4'h1) begin
                state_nxt.snap_state = ODC_SNAP_CAPTURE;
              end
            end else begin
              state_nxt.ivl_cnt = state_r.ivl_cnt - 8'h01;
            end
          end
          ODC_SNAP_CAPTURE: begin
            push              = 1'b1;
            state_nxt.group   = state_r.group + 4'h1;
            // An interval shorter than the count must not wrap the counter round
            if (state_r.ivl_cnt != '0) begin
              state_nxt.ivl_cnt = state_r.ivl_cnt - 8'h01;
            end
            if (state_r.group + 4'h1 >= nsamp) begin
              state_nxt.snap_state = ODC_SNAP_WAIT;
            end
          end
          default: begin
            state_nxt.snap_state = ODC_SNAP_WAIT;
          end
        endcase
      end
    end

    // A full buffer drops the sample rather than overwrite unread data
    push_ok = push & ~full;
    pop     = do_adv & ~empty;
    head    = odc_ptr_t'(state_r.rd_ptr + 3'h1);

    if (push_ok) begin
      state_nxt.mem[state_r.wr_ptr] = samp_data_i;
      state_nxt.wr_ptr              = odc_ptr_t'(state_r.wr_ptr + 3'h1);
    end
    if (pop) begin
      state_nxt.rd_ptr = head;
    end
    if (push_ok && !pop) begin
      state_nxt.depth = state_r.depth + 4'h1;
    end else if (pop && !push_ok) begin
      state_nxt.depth = state_r.depth - 4'h1;
    end

    // Interrupt only on the rising crossing; draining past it stays quiet
    state_nxt.irq   = state_r.buf_ctrl.fifo_mode && push_ok && !pop &&
                      (state_r.depth + 4'h1 == {1'b0, state_r.buf_ctrl.thresh});
    state_nxt.ready = state_r.buf_ctrl.fifo_mode &&
                      (state_nxt.depth >= {1'b0, state_r.buf_ctrl.thresh});

    // Pointer reset command
    if (do_ptr_rst) begin
      state_nxt.rd_ptr = `ODC_RD_PTR_INIT;
      state_nxt.wr_ptr = `ODC_WR_PTR_INIT;
      state_nxt.depth  = '0;
      state_nxt.ready  = state_r.buf_ctrl.fifo_mode && (state_r.buf_ctrl.thresh == '0);
      state_nxt.irq    = 1'b0;
    end

    // Global counter and accumulator reset, processing-clock side
    if (do_grst) begin
      state_nxt.rd_ptr     = `ODC_RD_PTR_INIT;
      state_nxt.wr_ptr     = `ODC_WR_PTR_INIT;
      state_nxt.depth      = '0;
      state_nxt.ready      = 1'b0;
      state_nxt.irq        = 1'b0;
      state_nxt.group      = '0;
      state_nxt.ivl_cnt    = state_r.buf_ctrl.interval;
      state_nxt.snap_state = ODC_SNAP_WAIT;
      state_nxt.chain_rst.halfband = 1'b1;
      state_nxt.chain_rst.fir      = 1'b1;
      state_nxt.chain_rst.agc      = 1'b1;
      state_nxt.chain_rst.resamp   = 1'b1;
      state_nxt.chain_rst.timing   = 1'b1;
    end

    // Input-domain side: carrier oscillator takes its phase offset
    if (in_rst_strobe) begin
      state_nxt.nco_phase = state_r.phase_cfg;
      state_nxt.nco_fb_en = 1'b1;
    end

    // Read data; command addresses and holes read as zero
    status           = '0;
    status.snap_busy = (state_r.snap_state == ODC_SNAP_CAPTURE);
    status.ready     = state_r.ready;
    status.full      = full;
    status.empty     = empty;
    status.depth     = state_r.depth;
    status.rd_ptr    = state_r.rd_ptr;
    status.wr_ptr    = state_r.wr_ptr;
    status.group     = state_r.group;
    if (req && !wb_we_i) begin
      case (idx)
        `ODC_IDX_BUF_CTRL:   state_nxt.rdata = 32'(state_r.buf_ctrl);
        `ODC_IDX_CHAIN_CTRL: state_nxt.rdata = 32'(state_r.chain_ctrl);
        `ODC_IDX_PHASE:      state_nxt.rdata = 32'(state_r.phase_cfg);
        `ODC_IDX_STATUS:     state_nxt.rdata = 32'(status);
        `ODC_IDX_SAMPLE:     state_nxt.rdata = 32'(state_r.mem[head]);
        default:             state_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r            <= '0;
      state_r.buf_ctrl   <= `ODC_RST_BUF_CTRL;
      state_r.chain_ctrl <= `ODC_RST_CHAIN_CTRL;
      state_r.phase_cfg  <= `ODC_RST_PHASE;
      state_r.rd_ptr     <= `ODC_RD_PTR_INIT;
      state_r.wr_ptr     <= `ODC_WR_PTR_INIT;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Decimator reset rides the input-domain strobe
  assign in_dom_rst_o            = in_rst_strobe;
  assign wb_dat_o                = state_r.rdata;
  assign wb_ack_o                = state_r.ack;
  assign buffer_interrupt_output = state_r.irq;
  assign buffer_ready_o          = state_r.ready;
  assign chain_rst_o             = state_r.chain_rst;
  assign nco_phase_o             = state_r.nco_phase;
  assign nco_fb_en_o             = state_r.nco_fb_en;

endmodule

`default_nettype wire

// ==== odc_sample_src.sv ====
/*
  Model of the processing chain that feeds output samples to the buffer.
  Assumes the bench calls send just after a rising edge of clk.
*/
`default_nettype none

module odc_sample_src #(
  parameter int DATA_W = 16
) (
  // Clock
  input  wire logic              clk,
  // Sample stream
  output var  logic              samp_valid_o,
  output var  logic [DATA_W-1:0] samp_data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    samp_valid_o = 1'b0;
    samp_data_o  = '0;
  end

  // Between samples the data lines carry the inverse, so a stale word is never mistaken for fresh
  task automatic send(input logic [DATA_W-1:0] d, input int gap);
    @(posedge clk);
    samp_valid_o <= 1'b1;
    samp_data_o  <= d;
    @(posedge clk);
    samp_valid_o <= 1'b0;
    samp_data_o  <= ~d;
    repeat (gap) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// ==== odc_buffer_ctrl_sva.sv ====
/*
  Port-level checker for the output buffer and command strobe block.
  Assumes ce stays high and the master drops stb after each ack.
*/
`default_nettype none
`include "odc_map.svh"

module odc_buffer_ctrl_sva
  import odc_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            sys_rst,
  // Wishbone
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  input  wire logic [31:0]     wb_dat_o,
  input  wire logic            wb_ack_o,
  // Outputs watched
  input  wire logic            sync_strobe_output,
  input  wire logic            buffer_interrupt_output,
  input  wire odc_chain_rst_t  chain_rst_o,
  input  wire logic            in_dom_rst_o,
  input  wire logic            nco_fb_en_o
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  logic [5:0] idx;
  logic       wr_ack;
  logic       sel_in_r;
  assign idx    = wb_adr_i[`ODC_IDX_HI:`ODC_IDX_LO];
  assign wr_ack = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;

  // Mirror of the sync alignment bit; the sync timing depends on it
  always_ff @(posedge clk) begin
    if (sys_rst) sel_in_r <= 1'b0;
    else if (wr_ack && idx == `ODC_IDX_CHAIN_CTRL && wb_sel_i[0]) sel_in_r <= wb_dat_i[`ODC_F_SYNC_SEL];
  end

  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sync_wr_s;
    wr_ack && idx == `ODC_IDX_SYNC;
  endsequence
  sequence grst_wr_s;
    wr_ack && idx == `ODC_IDX_GLOBAL_RST;
  endsequence

  bus_answer_a: assert property (req_s |=> wb_ack_o) else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  sync_proc_a: assert property (sync_wr_s ##0 !sel_in_r |=> sync_strobe_output) else $error("late sync");
  sync_input_a: assert property (sync_wr_s ##0 sel_in_r |-> ##[1:16] sync_strobe_output) else $error("no sync");
  sync_width_a: assert property (sync_strobe_output |=> !sync_strobe_output) else $error("sync too wide");
  chain_reset_a: assert property (grst_wr_s |-> chain_rst_o == 5'h1F) else $error("chain reset missing");
  input_reset_a: assert property (grst_wr_s |-> ##[0:16] in_dom_rst_o) else $error("input reset missing");
  feedback_on_a: assert property (in_dom_rst_o |=> nco_fb_en_o) else $error("feedback not enabled");
  intr_pulse_a: assert property (buffer_interrupt_output |=> !buffer_interrupt_output) else $error("long intr");
  cmd_read_a: assert property (wb_ack_o && !wb_we_i && idx >= `ODC_IDX_PTR_RST && idx <= `ODC_IDX_GLOBAL_RST
    |-> wb_dat_o == 32'h0) else $error("command address read not zero");
endmodule

`default_nettype wire

// ==== tb_top.sv ====
/*
  Self-checking bench for the output buffer and command strobe block.
  Assumes the sample source model and the checker are compiled first.
*/
`default_nettype none

module tb_top
  import odc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic           clk, sys_rst, ce, cyc, stb, we, in_clk, s_vld;
  logic           ack, sync_o, intr_o, rdy_o, in_rst, fb_en;
  logic [7:0]     adr;
  logic [3:0]     sel;
  logic [31:0]    wdat, rdat, q;
  logic [15:0]    s_dat, v;
  logic [9:0]     phase, nco_ph;
  odc_chain_rst_t chain_rst;
  int             n_errors, cmp_count, seed, n_sync, n_intr, n_chain, k;
  logic [15:0]    smp [$];

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Unrelated in phase to clk
  initial begin
    in_clk = 1'b0;
    forever #17 in_clk = ~in_clk;
  end

  always @(posedge clk) begin
    if (sync_o === 1'b1) n_sync++;
    if (intr_o === 1'b1) n_intr++;
    if (chain_rst !== 5'h00) n_chain++;
  end

  odc_sample_src i_src (.clk(clk), .samp_valid_o(s_vld), .samp_data_o(s_dat));

  odc_buffer_ctrl i_dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .input_sample_clock(in_clk), .samp_valid_i(s_vld), .samp_data_i(s_dat),
    .sync_strobe_output(sync_o), .buffer_interrupt_output(intr_o), .buffer_ready_o(rdy_o),
    .chain_rst_o(chain_rst), .in_dom_rst_o(in_rst), .nco_phase_o(nco_ph), .nco_fb_en_o(fb_en));

  function automatic logic [11:0] exp_st(input int st, input int rdn);
    int d;
    d = st - rdn;
    return {d == 8, d == 0, 4'(d), 3'((7 + rdn) % 8), 3'(st % 8)};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
    if (i == 20) begin
      check("bus ack", ack, 1'b1);
      results();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, $random(seed));
    check(nm, q, e);
  endtask

  task automatic st(input int s, input int r);
    wb(1'b0, 8'h68, 32'h0);
    check("status", {20'h0, q[15:4]}, {20'h0, exp_st(s, r)});
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  initial begin
    seed = 11878;
    {cyc, stb, we, sys_rst} = 4'h0;
    ce = 1'b1;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    do_reset();
    rchk("ctrl reset", 8'h54, 32'h0);
    rchk("unmapped", 8'h80, 32'h0);
    for (k = 0; k < 4; k++) rchk("cmd read", 8'h58 + 8'(4 * k), 32'h0);
    v = 16'($random(seed));
    wb(1'b1, 8'h54, {16'hFFFF, v});
    rchk("ctrl rw", 8'h54, {16'h0, v});
    // FIFO mode, threshold 3
    wb(1'b1, 8'h54, 32'h0000B000);
    wb(1'b1, 8'h58, $random(seed));
    st(0, 0);
    n_intr = 0;
    for (k = 1; k <= 9; k++) begin
      v = 16'($random(seed));
      smp.push_back(v);
      i_src.send(v, 3);
      check("intr count", n_intr, k >= 3);
      check("ready", rdy_o, k >= 3);
    end
    st(8, 0);
    rchk("sample", 8'h6C, {16'h0, smp[0]});
    for (k = 1; k <= 8; k++) begin
      wb(1'b1, 8'h5C, $random(seed));
      st(8, k);
      if (k < 8) rchk("sample", 8'h6C, {16'h0, smp[k]});
      check("ready", rdy_o, 8 - k >= 3);
    end
    check("intr count", n_intr, 1);
    for (k = 1; k <= 3; k++) begin
      i_src.send(16'($random(seed)), 3);
      check("intr refill", n_intr, 1 + (k == 3));
    end
    st(11, 8);
    // A sample offered while ce is low must leave no trace
    ce <= 1'b0;
    i_src.send(16'($random(seed)), 1);
    ce <= 1'b1;
    st(11, 8);
    for (k = 0; k < 2; k++) begin
      wb(1'b1, 8'h00, 32'(k) << 3);
      n_sync = 0;
      wb(1'b1, 8'h60, $random(seed));
      repeat (20) @(posedge clk);
      check("sync pulses", n_sync, 1);
    end
    phase = 10'($random(seed));
    wb(1'b1, 8'h04, {22'h3FFFFF, phase});
    n_chain = 0;
    check("feedback", fb_en, 1'b0);
    wb(1'b1, 8'h64, $random(seed));
    repeat (20) @(posedge clk);
    check("phase", nco_ph, phase);
    check("feedback", fb_en, 1'b1);
    check("chain resets", n_chain, 1);
    check("ready", rdy_o, 1'b0);
    st(0, 0);
    // Snapshot mode after a second reset: interval 4, three samples
    do_reset();
    wb(1'b1, 8'h54, 32'h00000043);
    wb(1'b1, 8'h58, $random(seed));
    check("ready", rdy_o, 1'b0);
    for (k = 1; k <= 6; k++) begin
      i_src.send(16'($random(seed)), 1);
      if (k == 5) begin
        st(3, 0);
        check("group", q[3:0], 4'h3);
      end
    end
    st(4, 0);
    check("snap busy", q[17], 1'b1);
    wb(1'b1, 8'h64, $random(seed));
    st(0, 0);
    check("group", q[3:0], 4'h0);
    check("snap busy", q[17], 1'b0);
    results();
  end
endmodule

bind odc_buffer_ctrl odc_buffer_ctrl_sva i_chk (
  .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sync_strobe_output(sync_strobe_output),
  .buffer_interrupt_output(buffer_interrupt_output), .chain_rst_o(chain_rst_o),
  .in_dom_rst_o(in_dom_rst_o), .nco_fb_en_o(nco_fb_en_o));

`default_nettype wire
